/* File: dicr_input_block.sv */
// Digital input front end: sampling, conditioning, routing and interlock
`timescale 1ns/1ps
// How it works
// - Every input owns a special-function bit low and a level bit high
// - Level of input n sits at bit 15+n, independent of special enables
// - Inputs are sampled once per millisecond; shorter pulses are seen only if they span a tick
// - Differential select 1 pairs six single-ended pins into three inputs
// - Special enable bit gates the low-half bit only, never the level bits
// - Low bits: 0 negative limit, 1 positive limit, 2 home, 3 interlock
// - Invert bit 1 makes a high pin read 0, for both halves
// - Force enable bit replaces the sampled pin value of that input
// - A forced input takes the matching force value bit
// - Raw word shows pin levels before inversion, forcing and routing
// - Threshold select output per input: 0 for 5 V, 1 for 24 V
// - Routing enable 1 turns routing on and preloads an identical table
// - Routing entry k picks the source for input word bit k
// - Code 0x80 is constant 1; 0x81 to 0x90 pick inverted inputs
// - Interlock bit 0 with interlock enabled raises the fault state
// - Interlock acts only while special enable bit 3 is set
module dicr_input_block #(
    parameter int TICK_CYCLES = dicr_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] inPin,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWriteData,
    output logic [31:0] regReadData,
    output logic regReadValid,
    output logic [31:0] inputWord,
    output logic [15:0] thresholdSelect,
    output logic diffMode,
    output logic interlockFault,
    output logic interlockTrip
);

    localparam int CNT_W = $clog2(TICK_CYCLES + 1);
    localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYCLES - 1);

    // ****************************************
    // Helper functions
    // ****************************************

    // True for selector codes that reach a routing table entry
    function automatic logic isRouteAddr(input logic [7:0] addr);
        isRouteAddr = (addr >= dicr_pkg::ADDR_ROUTE_BASE) &&
                      (addr <= dicr_pkg::ADDR_ROUTE_LAST);
    endfunction

    // Source decode of one routing entry; unlisted codes give 0
    function automatic logic routeSource(input logic [7:0] code,
                                         input logic [15:0] src);
        logic [6:0] sel;
        logic val;
        sel = code[6:0];
        val = 1'b0;
        if (sel == 7'h00) begin
            val = code[dicr_pkg::ROUTE_INV_BIT];
        end else if (sel <= dicr_pkg::ROUTE_INPUT_MAX) begin
            val = src[4'(sel - 7'h01)] ^ code[dicr_pkg::ROUTE_INV_BIT];
        end
        routeSource = val;
    endfunction

    // Table entry that reproduces the plain mapping for word bit b
    function automatic logic [7:0] preloadCode(input int b);
        if (b < dicr_pkg::LEVEL_BASE) begin
            preloadCode = 8'(b + 1);
        end else begin
            preloadCode = 8'(b - dicr_pkg::LEVEL_BASE + 1);
        end
    endfunction

    // ****************************************
    // Pin synchroniser and millisecond sampling
    // ****************************************
    logic [15:0] pinMeta;
    logic [15:0] pinSync;
    logic [CNT_W-1:0] tickCount;
    logic tick;
    logic [15:0] sampled;
    logic [15:0] next_sampled;
    logic diffSelect;

    // Two flops before any logic looks at the pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinMeta <= 16'h0000;
            pinSync <= 16'h0000;
        end else begin
            pinMeta <= inPin;
            pinSync <= pinMeta;
        end
    end

    // Free running divider gives a one-cycle tick every millisecond
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tickCount <= '0;
            tick <= 1'b0;
        end else if (tickCount == TICK_LAST) begin
            tickCount <= '0;
            tick <= 1'b1;
        end else begin
            tickCount <= tickCount + 1'b1;
            tick <= 1'b0;
        end
    end

    // Pairs share one receiver: minus on the even pin, plus on the odd
    always_comb begin
        next_sampled = pinSync;
        if (diffSelect) begin
            for (int p = 0; p < dicr_pkg::DIFF_PAIRS; p++) begin
                next_sampled[p] = pinSync[2*p+1] & ~pinSync[2*p];
            end
            next_sampled[dicr_pkg::SINGLE_PINS-1:dicr_pkg::DIFF_PAIRS] = '0;
        end
    end

    // Levels only move on the tick, so short glitches reach logic only if they span a tick
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sampled <= 16'h0000;
        end else if (tick) begin
            sampled <= next_sampled;
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    logic [31:0] specialEn;
    logic [31:0] invertMask;
    logic [31:0] forceEnMask;
    logic [31:0] forceValMask;
    logic [31:0] thresholdMask;
    logic routingEnable;
    logic routeTurnOn;
    logic [7:0] routeTable [0:31];

    assign routeTurnOn = regWrite && (regAddr == dicr_pkg::ADDR_ROUTE_EN) &&
                         regWriteData[0] && !routingEnable;

    // Plain settings, all zero after reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            specialEn <= dicr_pkg::CFG_RESET;
            invertMask <= dicr_pkg::CFG_RESET;
            forceEnMask <= dicr_pkg::CFG_RESET;
            forceValMask <= dicr_pkg::CFG_RESET;
            thresholdMask <= dicr_pkg::CFG_RESET;
            diffSelect <= 1'b0;
            routingEnable <= 1'b0;
        end else if (regWrite) begin
            case (regAddr)
                dicr_pkg::ADDR_SPECIAL_EN: specialEn <= regWriteData;
                dicr_pkg::ADDR_INVERT: invertMask <= regWriteData;
                dicr_pkg::ADDR_FORCE_EN: forceEnMask <= regWriteData;
                dicr_pkg::ADDR_FORCE_VAL: forceValMask <= regWriteData;
                dicr_pkg::ADDR_THRESHOLD: thresholdMask <= regWriteData;
                dicr_pkg::ADDR_DIFF_SEL: diffSelect <= regWriteData[0];
                dicr_pkg::ADDR_ROUTE_EN: routingEnable <= regWriteData[0];
                default: ;
            endcase
        end
    end

    // Turning routing on rewrites the table so nothing changes at the switch;
    // leaving routing keeps the table, so a later return reloads it again
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int b = 0; b < dicr_pkg::WORD_W; b++) begin
                routeTable[b] <= 8'h00;
            end
        end else if (routeTurnOn) begin
            for (int b = 0; b < dicr_pkg::WORD_W; b++) begin
                routeTable[b] <= preloadCode(b);
            end
        end else if (regWrite && isRouteAddr(regAddr)) begin
            routeTable[regAddr[4:0]] <= regWriteData[7:0];
        end
    end

    // Receiver thresholds and pairing go straight out of the registers
    assign thresholdSelect = thresholdMask[15:0];
    assign diffMode = diffSelect;

    // ****************************************
    // Conditioning and input word
    // ****************************************
    logic [15:0] condBits;
    logic [31:0] normalWord;
    logic [31:0] routedWord;
    logic [31:0] next_inputWord;

    // Forcing replaces the pin value first, inversion then acts on either
    assign condBits = ((forceEnMask[15:0] & forceValMask[15:0]) |
                       (~forceEnMask[15:0] & sampled)) ^ invertMask[15:0];

    // Plain mapping: same value in the low and the high half
    assign normalWord = {condBits, condBits};

    // One decoder per word bit; entry k drives bit k
    for (genvar b = 0; b < dicr_pkg::WORD_W; b++) begin : gRoute
        assign routedWord[b] = routeSource(routeTable[b], condBits);
    end

    // Special enables mask the function bits; bits 0..3 are the limit,
    // home and interlock functions, the level half is never masked
    assign next_inputWord = (routingEnable ? routedWord : normalWord) &
                            {16'hFFFF, specialEn[15:0]};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            inputWord <= 32'h0000_0000;
        end else begin
            inputWord <= next_inputWord;
        end
    end

    // ****************************************
    // Interlock release
    // ****************************************
    logic next_fault;

    // Released interlock puts the drive in error; the fault reaction
    // itself is chosen and run by the motion controller downstream
    assign next_fault = specialEn[dicr_pkg::BIT_INTERLOCK] &&
                        !inputWord[dicr_pkg::BIT_INTERLOCK];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            interlockFault <= 1'b0;
            interlockTrip <= 1'b0;
        end else begin
            interlockFault <= next_fault;
            interlockTrip <= next_fault && !interlockFault;
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    logic [31:0] next_readData;

    // Unknown selector codes read as zero
    always_comb begin
        next_readData = 32'h0000_0000;
        case (regAddr)
            dicr_pkg::ADDR_SPECIAL_EN: next_readData = specialEn;
            dicr_pkg::ADDR_INVERT: next_readData = invertMask;
            dicr_pkg::ADDR_FORCE_EN: next_readData = forceEnMask;
            dicr_pkg::ADDR_FORCE_VAL: next_readData = forceValMask;
            dicr_pkg::ADDR_RAW: next_readData = {16'h0000, sampled};
            dicr_pkg::ADDR_THRESHOLD: next_readData = thresholdMask;
            dicr_pkg::ADDR_DIFF_SEL: next_readData = {31'h0000_0000, diffSelect};
            dicr_pkg::ADDR_ROUTE_EN: next_readData = {31'h0000_0000, routingEnable};
            dicr_pkg::ADDR_INPUT_WORD: next_readData = inputWord;
            default: begin
                if (isRouteAddr(regAddr)) begin
                    next_readData = {24'h00_0000, routeTable[regAddr[4:0]]};
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regReadData <= 32'h0000_0000;
            regReadValid <= 1'b0;
        end else begin
            regReadValid <= regRead;
            if (regRead) begin
                regReadData <= next_readData;
            end
        end
    end

    // ****************************************
    // Assertions and covers
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_tick_gap: assert property (
        tick |=> !tick [*8]
    ) else $error("sample tick repeated too soon");

    chk_sample_hold: assert property (
        !tick |=> $stable(sampled)
    ) else $error("sampled levels moved without a tick");

    chk_diff_pair: assert property (
        tick && diffSelect |=> sampled[0] == $past(pinSync[1] & ~pinSync[0])
            && sampled[5:3] == 3'h0
    ) else $error("differential pairing wrong");

    chk_level_mirror: assert property (
        !routingEnable |=> inputWord[31:16] == $past(condBits)
    ) else $error("level half does not follow inputs");

    chk_special_gate: assert property (
        !routingEnable |=> inputWord[15:0] == $past(condBits & specialEn[15:0])
    ) else $error("special half not gated by enables");

    chk_invert_level: assert property (
        !routingEnable && invertMask[0] && !forceEnMask[0]
            |=> inputWord[16] == !$past(sampled[0])
    ) else $error("inversion not applied");

    chk_force_value: assert property (
        !routingEnable && forceEnMask[1] && !invertMask[1]
            |=> inputWord[17] == $past(forceValMask[1])
    ) else $error("forced value not used");

    chk_raw_read: assert property (
        regRead && regAddr == dicr_pkg::ADDR_RAW
            |=> regReadValid && regReadData == {16'h0000, $past(sampled)}
    ) else $error("raw word read wrong");

    chk_threshold_out: assert property (
        regWrite && regAddr == dicr_pkg::ADDR_THRESHOLD
            |=> thresholdSelect == $past(regWriteData[15:0])
    ) else $error("threshold select not driven");

    chk_route_preload: assert property (
        routeTurnOn |=> routingEnable && routeTable[0] == 8'h01
            && routeTable[16] == 8'h01 && routeTable[31] == 8'h10
    ) else $error("routing table not preloaded");

    chk_route_const: assert property (
        routingEnable && routeTable[31] == dicr_pkg::ROUTE_CONST_ONE |=> inputWord[31]
    ) else $error("constant one source wrong");

    chk_route_source: assert property (
        routingEnable && routeTable[0] == 8'h82 && specialEn[0]
            |=> inputWord[0] == !$past(condBits[1])
    ) else $error("inverted routed source wrong");

    chk_interlock_trip: assert property (
        specialEn[3] && !inputWord[3] |=> interlockFault ##1 !interlockTrip
    ) else $error("interlock release missed");

    chk_interlock_off: assert property (
        !specialEn[3] |=> !interlockFault
    ) else $error("interlock acted while disabled");

    cov_route_on: cover property (routeTurnOn ##1 routingEnable);
    cov_interlock: cover property ($rose(interlockTrip));
    cov_diff_tick: cover property (diffSelect && tick);
    cov_forced: cover property (forceEnMask[0] && tick);

endmodule

/* File: dicr_pkg.sv */
// Constants shared by the digital input conditioning and routing block
package dicr_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_INPUTS = 16;
    localparam int WORD_W = 32;
    localparam int ADDR_W = 8;
    localparam int DIFF_PAIRS = 3;
    localparam int SINGLE_PINS = 6;

    // ****************************************
    // Register selector codes on the register port
    // ****************************************
    localparam logic [7:0] ADDR_SPECIAL_EN = 8'h01;
    localparam logic [7:0] ADDR_INVERT = 8'h02;
    localparam logic [7:0] ADDR_FORCE_EN = 8'h03;
    localparam logic [7:0] ADDR_FORCE_VAL = 8'h04;
    localparam logic [7:0] ADDR_RAW = 8'h05;
    localparam logic [7:0] ADDR_THRESHOLD = 8'h06;
    localparam logic [7:0] ADDR_DIFF_SEL = 8'h07;
    localparam logic [7:0] ADDR_ROUTE_EN = 8'h08;
    localparam logic [7:0] ADDR_INPUT_WORD = 8'h09;
    localparam logic [7:0] ADDR_ROUTE_BASE = 8'h40;
    localparam logic [7:0] ADDR_ROUTE_LAST = 8'h5F;

    // ****************************************
    // Field positions, source codes, reset values
    // ****************************************
    localparam int BIT_NEG_LIMIT = 0;
    localparam int BIT_POS_LIMIT = 1;
    localparam int BIT_HOME = 2;
    localparam int BIT_INTERLOCK = 3;
    localparam int LEVEL_BASE = 16;
    localparam int ROUTE_INV_BIT = 7;
    localparam logic [6:0] ROUTE_INPUT_MAX = 7'h10;
    localparam logic [7:0] ROUTE_CONST_ONE = 8'h80;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SAMPLE_PERIOD_NS = 1000000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

endpackage

/* File: dicr_switch_model.sv */
// Behavioural bank of field switches driving the physical input pins
`timescale 1ns/1ps
module dicr_switch_model (
    input wire logic clk,
    input wire logic [15:0] target,
    input wire logic [3:0] bounceLen,
    output logic [15:0] inPin
);
    logic [15:0] settled = 16'h0000;
    logic [3:0] bounceLeft = 4'h0;
    int seed = 4711;

    initial begin
        inPin = 16'h0000;
    end

    // Contacts chatter after each change; a zero length models a clean
    // electronic sensor, a long one a slow mechanical switch. Chatter stays
    // shorter than one sampling period so the settled level always wins.
    always @(posedge clk) begin
        if (target !== settled) begin
            settled <= target;
            bounceLeft <= bounceLen;
            inPin <= (bounceLen == 4'h0) ? target : target ^ 16'($random(seed));
        end else if (bounceLeft > 4'h1) begin
            bounceLeft <= bounceLeft - 4'h1;
            inPin <= settled ^ 16'($random(seed));
        end else begin
            bounceLeft <= 4'h0;
            inPin <= settled;
        end
    end
endmodule

/* File: digital_input_conditioning_routing_tb.sv */
// Self-checking bench for the digital input conditioning and routing block
`timescale 1ns/1ps
module digital_input_conditioning_routing_tb;
    // ****************************************
    // Signals and bench state
    // ****************************************
    localparam int TICK = 16;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] target = 16'h0000;
    logic [3:0] bounceLen = 4'h0;
    logic [15:0] inPin;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWriteData = 32'h0000_0000;
    logic [31:0] regReadData;
    logic regReadValid;
    logic [31:0] inputWord;
    logic [15:0] thresholdSelect;
    logic diffMode;
    logic interlockFault;
    logic interlockTrip;
    int failures = 0;
    int compares = 0;
    int seed = 95737;
    int cyc = 0;
    int lastCyc = 0;
    int trips = 0;
    int rises = 0;
    logic sampChk = 1'b0;
    logic lastChk = 1'b0;
    logic prevFault = 1'b0;
    logic [31:0] lastWord = 32'h0000_0000;
    logic [31:0] spEn = 32'h0000_0000;
    logic [31:0] inv = 32'h0000_0000;
    logic [31:0] fe = 32'h0000_0000;
    logic [31:0] fv = 32'h0000_0000;
    logic [31:0] rd;
    logic [31:0] back;
    logic diffOn = 1'b0;
    logic routeOn = 1'b0;
    logic [7:0] tbl [32] = '{default: 8'h00};
    logic [7:0] regs [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06};

    // Free-running 200 MHz clock
    always #2.5 clk = ~clk;

    dicr_switch_model i_switches (.clk(clk), .target(target), .bounceLen(bounceLen),
        .inPin(inPin));

    dicr_input_block #(.TICK_CYCLES(TICK)) i_dut (.clk(clk), .reset_n(reset_n),
        .inPin(inPin), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWriteData(regWriteData), .regReadData(regReadData),
        .regReadValid(regReadValid), .inputWord(inputWord),
        .thresholdSelect(thresholdSelect), .diffMode(diffMode),
        .interlockFault(interlockFault), .interlockTrip(interlockTrip));

    // ****************************************
    // Reference model
    // ****************************************
    function automatic logic [15:0] samp(input logic [15:0] p);
        logic [15:0] s;
        s = p;
        if (diffOn) begin
            s[5:0] = {3'b000, p[5] & ~p[4], p[3] & ~p[2], p[1] & ~p[0]};
        end
        return s;
    endfunction

    function automatic logic srcBit(input logic [7:0] code, input logic [15:0] c);
        if (code[6:0] >= 7'h01 && code[6:0] <= 7'h10) begin
            return c[code[6:0] - 7'h01] ^ code[7];
        end
        return code == 8'h80;
    endfunction

    function automatic logic [31:0] expWord(input logic [15:0] p);
        logic [15:0] c;
        logic [31:0] w;
        c = ((fe[15:0] & fv[15:0]) | (~fe[15:0] & samp(p))) ^ inv[15:0];
        w = {c, c};
        for (int b = 0; b < 32; b++) begin
            if (routeOn) begin
                w[b] = srcBit(tbl[b], c);
            end
        end
        return {w[31:16], w[15:0] & spEn[15:0]};
    endfunction

    // Legal codes first, then a few that must read as constant 0
    function automatic logic [7:0] codeOf(input int i);
        logic [7:0] odd [4] = '{8'h11, 8'h7F, 8'h91, 8'hFF};
        if (i < 17) return 8'(i);
        if (i < 34) return 8'(i + 111);
        return odd[i - 34];
    endfunction

    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_sim();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    // Read answer is awaited for a few cycles only; silence ends the run
    task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
        int i;
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        d = 32'hdead_beef;
        for (i = 0; i < 4 && d === 32'hdead_beef; i++) begin
            #1;
            if (regReadValid === 1'b1) d = regReadData;
            else @(posedge clk);
        end
        if (regReadValid !== 1'b1) begin
            failures++;
            end_sim();
        end
    endtask

    task automatic pins(input logic [15:0] p, input logic [3:0] b);
        @(posedge clk);
        target <= p;
        bounceLen <= b;
    endtask

    task automatic checkAll();
        logic [31:0] e;
        repeat (3 * TICK) @(posedge clk);
        #1;
        e = expWord(target);
        chk("inputWord", e, inputWord);
        chk("interlock fault", {31'h0, spEn[3] & ~e[3]}, {31'h0, interlockFault});
        rdReg(dicr_pkg::ADDR_RAW, rd);
        chk("raw levels", {16'h0000, samp(target)}, rd);
        rdReg(dicr_pkg::ADDR_INPUT_WORD, rd);
        chk("input word register", e, rd);
    endtask

    task automatic cfg();
        wr(dicr_pkg::ADDR_SPECIAL_EN, spEn);
        wr(dicr_pkg::ADDR_INVERT, inv);
        wr(dicr_pkg::ADDR_FORCE_EN, fe);
        wr(dicr_pkg::ADDR_FORCE_VAL, fv);
    endtask

    // Input word may only move on the sampling grid while settings stand still;
    // every trip pulse must coincide with a rising fault level
    always @(posedge clk) begin
        cyc++;
        if (reset_n === 1'b1 && inputWord !== lastWord) begin
            if (sampChk && lastChk) chk("sample spacing", 0, 32'((cyc - lastCyc) % TICK));
            lastCyc = cyc;
            lastChk = sampChk;
            lastWord = inputWord;
        end
        if (reset_n === 1'b1 && (interlockTrip === 1'b1 || (interlockFault && !prevFault))) begin
            chk("interlock trip", {31'h0, interlockFault & ~prevFault}, {31'h0, interlockTrip});
            trips += (interlockTrip === 1'b1);
            rises += (interlockFault === 1'b1);
        end
        prevFault = interlockFault;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk("inputWord after reset", 32'h0, inputWord);
        for (int a = 1; a <= 9; a++) begin
            rdReg(8'(a), rd);
            chk("register after reset", 32'h0, rd);
        end
        foreach (regs[i]) begin
            wr(8'h20, $random(seed));
            wr(dicr_pkg::ADDR_RAW, $random(seed));
            wr(dicr_pkg::ADDR_INPUT_WORD, $random(seed));
            rd = $random(seed);
            wr(regs[i], rd);
            #1;
            if (regs[i] == 8'h06) chk("threshold pins", {16'h0000, rd[15:0]}, {16'h0000, thresholdSelect});
            rdReg(regs[i], back);
            chk("register readback", rd, back);
            rdReg(8'h20, rd);
            chk("unmapped read", 32'h0, rd);
            rdReg(dicr_pkg::ADDR_RAW, rd);
            chk("read-only raw", 32'h0, rd);
        end
        // Random settings and levels in normal mode
        for (int it = 0; it < 24; it++) begin
            spEn = $random(seed);
            inv = $random(seed);
            fe = (it < 4) ? 32'h0 : $random(seed);
            fv = $random(seed);
            cfg();
            pins($random(seed), 4'(it));
            checkAll();
        end
        sampChk = 1'b1;
        for (int it = 0; it < 8; it++) begin
            pins($random(seed), 4'(it * 2));
            checkAll();
        end
        sampChk = 1'b0;
        wr(dicr_pkg::ADDR_DIFF_SEL, 32'h1);
        diffOn = 1'b1;
        #1;
        chk("diff mode", 32'h1, {31'h0, diffMode});
        for (int it = 0; it < 8; it++) begin
            pins($random(seed), 4'h0);
            checkAll();
        end
        wr(dicr_pkg::ADDR_DIFF_SEL, 32'h0);
        diffOn = 1'b0;
        // Routing is switched on once and left on
        wr(dicr_pkg::ADDR_ROUTE_EN, 32'h1);
        routeOn = 1'b1;
        for (int b = 0; b < 32; b++) begin
            tbl[b] = (b < 16) ? 8'(b + 1) : 8'(b - 15);
            rdReg(8'(b + 64), rd);
            chk("route preload", {24'h0, tbl[b]}, rd);
        end
        checkAll();
        // Enable input 1's function so the inverted source on bit 0 stays visible
        spEn[0] = 1'b1;
        wr(dicr_pkg::ADDR_SPECIAL_EN, spEn);
        for (int it = 0; it < 3; it++) begin
            for (int b = 0; b < 32; b++) begin
                tbl[b] = codeOf((b + it * 32) % 38);
                if (it == 0 && b == 0) tbl[b] = 8'h82;
                if (it == 0 && b == 31) tbl[b] = dicr_pkg::ROUTE_CONST_ONE;
                wr(8'(b + 64), {24'h0, tbl[b]});
            end
            pins($random(seed), 4'h3);
            checkAll();
        end
        // Only the interlock sensor is wired, on input 4
        spEn = 32'h0000_0008;
        fe = 32'h0;
        inv = 32'h0;
        cfg();
        tbl[3] = 8'h04;
        wr(8'h43, 32'h4);
        pins(16'h0008, 4'h0);
        checkAll();
        pins(16'h0000, 4'h5);
        checkAll();
        spEn = 32'h0;
        wr(dicr_pkg::ADDR_SPECIAL_EN, spEn);
        checkAll();
        chk("trip count", rises, trips);
        // Second reset in mid-run clears settings and the table
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("inputWord in reset", 32'h0, inputWord);
        reset_n <= 1'b1;
        rdReg(dicr_pkg::ADDR_ROUTE_EN, rd);
        chk("routing after reset", 32'h0, rd);
        rdReg(8'h43, rd);
        chk("table after reset", 32'h0, rd);
        end_sim();
    end
endmodule
